//--- core/apmc_pkg.sv
// Package: constants and types for the converter power mode and output coding block
package apmc_pkg;
   // ****************************************
   // Widths and codes
   // ****************************************
   localparam int APMC_RES_W = 12;
   localparam int APMC_CODES = 4096;
   localparam logic [APMC_RES_W-1:0] APMC_MSB_FLIP = 12'h800;
   localparam logic [APMC_RES_W-1:0] APMC_ZERO = 12'h000;
   localparam logic [1:0] APMC_PM_SLEEP = 2'h0;
   localparam logic [1:0] APMC_PM_FULL_BETWEEN = 2'h1;
   localparam logic [1:0] APMC_PM_FULL_DOWN = 2'h2;
   localparam logic [1:0] APMC_PM_PART_BETWEEN = 2'h3;

   // ****************************************
   // Timing
   // ****************************************
   localparam int APMC_CLK_PERIOD_NS = 10;
   localparam int APMC_WAKE_US = 5;
   localparam int APMC_WAKE_CYC = (APMC_WAKE_US * 1000 + APMC_CLK_PERIOD_NS - 1)
      / APMC_CLK_PERIOD_NS;
   localparam int APMC_CNT_W = 13;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      APMC_MODE_UP,
      APMC_MODE_FULL_BETWEEN,
      APMC_MODE_FULL_DOWN,
      APMC_MODE_PART_BETWEEN
   } apmc_mode_e;

   typedef struct packed {
      logic power_mode_bit_hi;
      logic power_mode_bit_lo;
   } apmc_ctrl_s;

   typedef struct packed {
      logic core_on;
      logic ref_on;
      logic ready;
   } apmc_pwr_s;

   typedef logic [APMC_CNT_W-1:0] apmc_cnt_t;
endpackage

//--- core/apmc_coder.sv
// Output code formatter: straight binary or two's complement
`timescale 1ns/10ps
module apmc_coder (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic bipolar,
   input wire logic raw_valid,
   input wire logic [apmc_pkg::APMC_RES_W-1:0] raw_code,
   output logic [apmc_pkg::APMC_RES_W-1:0] result,
   output logic result_valid
);
   import apmc_pkg::*;

   // Raw code is offset binary over the full span, one step is full scale / 4096
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         result <= APMC_ZERO;
      end else if (raw_valid) begin
         if (bipolar) begin
            result <= raw_code ^ APMC_MSB_FLIP;
         end else begin
            result <= raw_code;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         result_valid <= 1'b0;
      end else begin
         result_valid <= raw_valid;
      end
   end

   coding_bip_a:
      assert property (@(posedge clk) disable iff (sys_rst)
      raw_valid && bipolar |=> result == ($past(raw_code) ^ APMC_MSB_FLIP))
      else $error("bipolar code not two's complement");
   coding_uni_a:
      assert property (@(posedge clk) disable iff (sys_rst)
      raw_valid && !bipolar |=> result == $past(raw_code))
      else $error("unipolar code not straight binary");
endmodule // apmc_coder

//--- core/apmc_top.sv
// Power mode decode, power sequencing and result coding for the converter
`timescale 1ns/10ps
module apmc_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire apmc_pkg::apmc_ctrl_s ctrl,
   input wire logic sleep_pin,
   input wire logic conversion_start_pulse_n,
   input wire logic busy,
   input wire logic calibrating,
   input wire logic bipolar,
   input wire logic raw_valid,
   input wire logic [apmc_pkg::APMC_RES_W-1:0] raw_code,
   output apmc_pkg::apmc_mode_e mode,
   output apmc_pkg::apmc_pwr_s pwr,
   output logic [apmc_pkg::APMC_RES_W-1:0] result,
   output logic result_valid
);
   import apmc_pkg::*;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic sleep_meta;
   logic sleep_sync;
   logic start_meta;
   logic start_sync;
   logic start_prev;
   logic start_fall;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sleep_meta <= 1'b1;
         sleep_sync <= 1'b1;
      end else begin
         sleep_meta <= sleep_pin;
         sleep_sync <= sleep_meta;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         start_meta <= 1'b1;
         start_sync <= 1'b1;
         start_prev <= 1'b1;
      end else begin
         start_meta <= conversion_start_pulse_n;
         start_sync <= start_meta;
         start_prev <= start_sync;
      end
   end

   assign start_fall = start_prev && !start_sync;

   logic busy_prev;
   logic busy_fall;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy_prev <= 1'b0;
      end else begin
         busy_prev <= busy;
      end
   end

   assign busy_fall = busy_prev && !busy;

   // ****************************************
   // Mode decode
   // ****************************************
   // Decoding is a pure function so the sequencer and checks agree
   function automatic apmc_mode_e decode_mode(input apmc_ctrl_s c, input logic slp);
      unique case ({c.power_mode_bit_hi, c.power_mode_bit_lo})
         APMC_PM_SLEEP: decode_mode = slp ? APMC_MODE_UP : APMC_MODE_FULL_BETWEEN;
         APMC_PM_FULL_BETWEEN: decode_mode = APMC_MODE_FULL_BETWEEN;
         APMC_PM_FULL_DOWN: decode_mode = APMC_MODE_FULL_DOWN;
         APMC_PM_PART_BETWEEN: decode_mode = APMC_MODE_PART_BETWEEN;
      endcase
   endfunction

   apmc_mode_e next_mode;

   // Calibration masks the sleep pin in decode; software-selected modes still decode, but the sequencer holds APMC_ST_ON while calibrating
   always_comb begin
      next_mode = decode_mode(ctrl, sleep_sync || calibrating);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode <= APMC_MODE_UP;
      end else begin
         mode <= next_mode;
      end
   end

   // ****************************************
   // Power sequencer
   // ****************************************
   typedef enum logic [1:0] {
      APMC_ST_ON,
      APMC_ST_DOWN,
      APMC_ST_WAKE
   } apmc_state_e;

   apmc_state_e state;
   apmc_cnt_t wake_cnt;
   logic between;

   assign between = (mode == APMC_MODE_FULL_BETWEEN) || (mode == APMC_MODE_PART_BETWEEN);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= APMC_ST_ON;
      end else begin
         unique case (state)
            APMC_ST_ON: begin
               if (mode == APMC_MODE_FULL_DOWN && !calibrating) begin
                  state <= APMC_ST_DOWN;
               end else if (between && busy_fall && !calibrating) begin
                  state <= APMC_ST_DOWN;
               end
            end
            APMC_ST_DOWN: begin
               if (mode == APMC_MODE_UP) begin
                  state <= APMC_ST_WAKE;
               end else if (between && start_fall) begin
                  state <= APMC_ST_WAKE;
               end
            end
            APMC_ST_WAKE: begin
               if (mode == APMC_MODE_FULL_DOWN) begin
                  state <= APMC_ST_DOWN;
               end else if (wake_cnt == apmc_cnt_t'(APMC_WAKE_CYC - 1)) begin
                  state <= APMC_ST_ON;
               end
            end
            // Two state bits carry one unused code; fall back to powered
            default: begin
               state <= APMC_ST_ON;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wake_cnt <= '0;
      end else if (state == APMC_ST_WAKE) begin
         wake_cnt <= wake_cnt + apmc_cnt_t'(1);
      end else begin
         wake_cnt <= '0;
      end
   end

   // Partial modes keep the reference up so wake-up is not slowed by recharge
   logic next_ref_on;

   always_comb begin
      next_ref_on = 1'b1;
      if (state == APMC_ST_DOWN && mode != APMC_MODE_PART_BETWEEN) begin
         next_ref_on = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pwr <= '{core_on: 1'b1, ref_on: 1'b1, ready: 1'b1};
      end else begin
         pwr.core_on <= (state != APMC_ST_DOWN);
         pwr.ref_on <= next_ref_on;
         pwr.ready <= (state == APMC_ST_ON);
      end
   end

   // ****************************************
   // Result coding
   // ****************************************
   apmc_coder u_coder (
      .clk(clk),
      .sys_rst(sys_rst),
      .bipolar(bipolar),
      .raw_valid(raw_valid),
      .raw_code(raw_code),
      .result(result),
      .result_valid(result_valid)
   );

   // ****************************************
   // Checks
   // ****************************************
   mode_follow_a:
      assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |=> mode == $past(next_mode))
      else $error("mode did not follow controls");
   awake_mode_a:
      assert property (@(posedge clk) disable iff (sys_rst)
      mode == APMC_MODE_UP && $past(mode) == APMC_MODE_UP && state == APMC_ST_ON
      |=> state == APMC_ST_ON)
      else $error("powered down in full power-up mode");
   sleep_low_a:
      assert property (@(posedge clk) disable iff (sys_rst)
      ctrl == APMC_PM_SLEEP && !sleep_sync && !calibrating
      |=> mode == APMC_MODE_FULL_BETWEEN)
      else $error("sleep low did not select full power-down between");
   perm_down_a:
      assert property (@(posedge clk) disable iff (sys_rst)
      ctrl == APMC_PM_FULL_DOWN |=> mode == APMC_MODE_FULL_DOWN)
      else $error("mode bits 10 not permanent power-down");
   full_ref_off_a:
      assert property (@(posedge clk) disable iff (sys_rst)
      state == APMC_ST_DOWN && mode != APMC_MODE_PART_BETWEEN
      |=> !pwr.ref_on && !pwr.core_on)
      else $error("reference on in full power-down");
   part_ref_on_a:
      assert property (@(posedge clk) disable iff (sys_rst)
      state == APMC_ST_DOWN && mode == APMC_MODE_PART_BETWEEN |=> pwr.ref_on && !pwr.core_on)
      else $error("reference off in partial power-down");
   busy_down_a:
      assert property (@(posedge clk) disable iff (sys_rst)
      state == APMC_ST_ON && between && busy_fall && !calibrating |=> state == APMC_ST_DOWN)
      else $error("no power-down at end of conversion");
   wake_time_a:
      assert property (@(posedge clk) disable iff (sys_rst)
      $rose(state == APMC_ST_WAKE) && mode != APMC_MODE_FULL_DOWN
      |-> ##[499:500] state != APMC_ST_WAKE)
      else $error("wake time not 5 us");
   // Upper bound above; this one catches a wake that ends early
   wake_len_a:
      assert property (@(posedge clk) disable iff (sys_rst)
      state == APMC_ST_ON && $past(state) == APMC_ST_WAKE
      |-> $past(state, APMC_WAKE_CYC) == APMC_ST_WAKE)
      else $error("wake shorter than 5 us");
   cal_hold_a:
      assert property (@(posedge clk) disable iff (sys_rst)
      calibrating && state == APMC_ST_ON |=> state == APMC_ST_ON)
      else $error("powered down during calibration");
endmodule // apmc_top

//--- dv/apmc_host_model.sv
// Host model: drives the power mode bits and the sleep pin
`timescale 1ns/10ps
module apmc_host_model (
   input wire logic clk,
   input wire logic use_pin,
   input wire logic [1:0] mode_req,
   input wire logic sleep_req,
   output apmc_pkg::apmc_ctrl_s ctrl,
   output logic sleep_pin
);
   import apmc_pkg::*;
   // One driver per output; the first falling edge lands inside reset
   // Requests land one falling edge late, like a real register write
   always @(negedge clk) begin
      ctrl <= use_pin ? 2'h0 : mode_req;
      sleep_pin <= sleep_req;
   end
endmodule // apmc_host_model

//--- dv/tb_apmc_top.sv
// Self-checking testbench for the power mode and output coding block
`timescale 1ns/10ps
module tb_apmc_top;
   import apmc_pkg::*;
   logic clk, sys_rst, use_pin, sleep_req, sleep_pin, start_n, busy, calibrating;
   logic bipolar, raw_valid, result_valid;
   logic [1:0] mode_req;
   logic [11:0] raw_code, result;
   logic [11:0] codes [4] = '{12'h000, 12'h7FF, 12'h800, 12'hFFF};
   // Two's complement of the same samples: bottom of span is most negative
   logic [11:0] codes_bip [4] = '{12'h800, 12'hFFF, 12'h000, 12'h7FF};
   apmc_ctrl_s ctrl;
   apmc_mode_e mode;
   apmc_pwr_s pwr;
   int mismatches = 0;
   int checks = 0;

   apmc_host_model host (.clk(clk), .use_pin(use_pin), .mode_req(mode_req),
      .sleep_req(sleep_req), .ctrl(ctrl), .sleep_pin(sleep_pin));
   apmc_top uut (.clk(clk), .sys_rst(sys_rst), .ctrl(ctrl), .sleep_pin(sleep_pin),
      .conversion_start_pulse_n(start_n), .busy(busy), .calibrating(calibrating),
      .bipolar(bipolar), .raw_valid(raw_valid), .raw_code(raw_code), .mode(mode),
      .pwr(pwr), .result(result), .result_valid(result_valid));

   always #5 clk = ~clk;

   // ****************************************
   // Helpers
   // ****************************************
   task tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task give_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task guard(input int n, input int lim);
      if (n >= lim) begin
         mismatches++;
         give_verdict();
      end
   endtask

   // End of a conversion: busy high, then its falling edge
   task convert;
      busy <= 1'b1;
      tick(2);
      busy <= 1'b0;
      tick(4);
   endtask

   // Start pin falls, core wakes, ready follows after the wake time
   task wake;
      int n;
      start_n <= 1'b0;
      n = 0;
      while (pwr.core_on !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      guard(n, 20);
      chk("pwr_wake", 12'(pwr), 12'h6);
      n = 0;
      while (pwr.ready !== 1'b1 && n < 600) begin
         tick(1);
         n++;
      end
      guard(n, 600);
      chk("wake_len", 12'(n >= APMC_WAKE_CYC - 2 && n <= APMC_WAKE_CYC + 2), 12'h1);
      start_n <= 1'b1;
      tick(4);
   endtask

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      clk = 0;
      sys_rst = 1;
      use_pin = 0;
      mode_req = 2'h0;
      sleep_req = 1;
      start_n = 1;
      busy = 0;
      calibrating = 0;
      bipolar = 0;
      raw_valid = 0;
      raw_code = 12'h000;
      tick(2);
      sys_rst <= 1'b0;
      tick(6);
      chk("mode_up", 12'(mode), 12'(APMC_MODE_UP));
      convert();
      chk("pwr_up", 12'(pwr), 12'h7);
      $display("test reset_and_up done");
      // Back to back results in both codings, boundary codes only
      for (int b = 0; b < 2; b++) begin
         for (int i = 0; i < 4; i++) begin
            bipolar <= b[0];
            raw_code <= codes[i];
            raw_valid <= 1'b1;
            tick(1);
            chk("valid", 12'(result_valid), 12'h1);
            chk("result", result, b ? codes_bip[i] : codes[i]);
         end
      end
      raw_valid <= 1'b0;
      tick(1);
      chk("valid_end", 12'(result_valid), 12'h0);
      $display("test coding done");
      // Software modes between conversions: full, then partial
      for (int m = 1; m < 4; m += 2) begin
         mode_req <= 2'(m);
         tick(4);
         chk("mode_sw", 12'(mode), 12'(m));
         convert();
         chk("pwr_down", 12'(pwr), m == 3 ? 12'h2 : 12'h0);
         wake();
      end
      mode_req <= APMC_PM_FULL_DOWN;
      tick(6);
      chk("pwr_off", 12'(pwr), 12'h0);
      chk("mode_off", 12'(mode), 12'(APMC_MODE_FULL_DOWN));
      mode_req <= APMC_PM_SLEEP;
      start_n <= 1'b0;
      tick(600);
      chk("pwr_back", 12'(pwr), 12'h7);
      start_n <= 1'b1;
      $display("test software_modes done");
      // Hardware control through the sleep pin
      use_pin <= 1'b1;
      sleep_req <= 1'b0;
      tick(8);
      chk("mode_pin", 12'(mode), 12'(APMC_MODE_FULL_BETWEEN));
      convert();
      chk("pwr_pin", 12'(pwr), 12'h0);
      wake();
      calibrating <= 1'b1;
      convert();
      chk("pwr_cal", 12'(pwr), 12'h7);
      chk("mode_cal", 12'(mode), 12'(APMC_MODE_UP));
      calibrating <= 1'b0;
      $display("test sleep_pin done");
      give_verdict();
   end
endmodule // tb_apmc_top
